/* incremental_angle_output_encoder.sv */
/*
 Incremental output stage: quadrature, step/direction and commutation outputs
 derived from a measured angle. Assumes angle_in is a 12-bit word from an
 asynchronous front end and mode_pin comes from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Clockwise: first phase leads second by a quarter cycle (one LSB).
// - Counter-clockwise: second phase leads first by a quarter cycle.
// - Marker pulse at programmed zero angle, one LSB wide.
// - Exactly one marker pulse per full rotation.
// - Step/direction: one LSB step pulse per resolution increment; step_q follows pos[0], so one pulse per two increments.
// - Step/direction: sense output shows rotation direction.
// - Step/direction: index equals quadrature marker timing and width.
// - Commutation: three phases 120 electrical degrees apart.
// - Commutation pulses per rotation: 2, 4, 6 or 16; the 16 setting uses 24 sectors, the rate for 8.
// - Four pulses swaps phase one and phase three pins.
// - Mode pin low runs outputs, high selects configuration mode.
// - Config mode: data on pin 8, clock on pin 7.
// - Resolution 8 to 12 bits defines one LSB.
// - Three output types, exactly one drives the pins.
// - Options: default, linear output, full 360-degree detection.
module incremental_angle_output_encoder
	import encoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mode_pin,
	input wire logic [ANGLE_BITS-1:0] angle_in,
	input wire encoder_pkg::enc_cfg_s cfg,
	input wire logic sda_drive_low,
	input wire logic scl_drive_low,
	output encoder_pkg::pins_s pins_out,
	output logic pin8_oe_n,
	output logic pin7_oe_n,
	output logic cfg_mode,
	output logic linear_enable,
	output logic full_turn_detect
);
	import encoder_pkg::*;

	logic [ANGLE_BITS-1:0] angle_s1;
	logic [ANGLE_BITS-1:0] angle_s2;
	logic mode_s1;
	logic mode_s2;
	logic [ANGLE_BITS-1:0] rel_angle;
	logic [ANGLE_BITS-1:0] scaled;
	logic [ANGLE_BITS-1:0] pos;
	logic step_ev;
	logic cw;
	logic [1:0] gray;
	logic marker;
	logic step_q;
	logic dir_q;
	logic [2:0] hall;
	logic [4:0] sector_count;
	logic [ANGLE_BITS+4:0] sec_prod;
	logic [4:0] sector;
	pins_s func_pins;
	logic [3:0] res_eff;

	// Two-stage synchronisers for the pin and the front-end angle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			angle_s1 <= '0;
			angle_s2 <= '0;
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
		end else begin
			angle_s1 <= angle_in;
			angle_s2 <= angle_s1;
			mode_s1 <= mode_pin;
			mode_s2 <= mode_s1;
		end
	end

	// Out-of-range resolution falls back to RES_RESET (12 bits)
	always_comb begin
		if (cfg.res_bits < 4'(RES_MIN) || cfg.res_bits > 4'(RES_MAX)) begin
			res_eff = RES_RESET;
		end else begin
			res_eff = cfg.res_bits;
		end
	end

	// Angle relative to the programmed zero, truncated to the resolution
	assign rel_angle = angle_s2 - cfg.zero_angle;
	assign scaled = rel_angle >> (4'(RES_MAX) - res_eff);

	angle_stepper #(
		.WIDTH(ANGLE_BITS)
	) u_stepper (
		.clk(clk),
		.rst(rst),
		.target(scaled),
		.res(res_eff),
		.pos(pos),
		.step(step_ev),
		.cw(cw)
	);

	// Gray quadrature counter follows the tracked position
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gray <= GRAY_RESET;
		end else if (step_ev) begin
			if (cw) begin
				gray <= {~gray[0], gray[1]};
			end else begin
				gray <= {gray[0], ~gray[1]};
			end
		end
	end

	// Marker high while tracked position sits at zero: one LSB, once per turn
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			marker <= 1'b0;
		end else begin
			marker <= (pos == '0);
		end
	end

	// Step pulse is one LSB wide: toggles high on odd positions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_q <= 1'b0;
			dir_q <= 1'b1;
		end else begin
			step_q <= pos[0];
			dir_q <= cw;
		end
	end

	// Commutation sectors per rotation
	always_comb begin
		unique case (cfg.poles)
			POLES_2: sector_count = 5'h06;
			POLES_4: sector_count = 5'h0C;
			POLES_6: sector_count = 5'h12;
			POLES_16: sector_count = 5'h18;
		endcase
	end

	// Sector index from the full-resolution relative angle
	assign sec_prod = {5'h00, rel_angle} * {12'h000, sector_count};
	assign sector = sec_prod[ANGLE_BITS+4:ANGLE_BITS];

	// Six-step pattern, phases 120 electrical degrees apart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hall <= HALL_RESET;
		end else begin
			unique case (5'(sector % 5'h06))
				5'h00: hall <= 3'b101;
				5'h01: hall <= 3'b100;
				5'h02: hall <= 3'b110;
				5'h03: hall <= 3'b010;
				5'h04: hall <= 3'b011;
				default: hall <= 3'b001;
			endcase
		end
	end

	// Select the one active output type
	always_comb begin
		unique case (cfg.out_type)
			COMMUTATION_OUTPUT_TYPE: begin
				if (cfg.poles == POLES_4) begin
					func_pins = '{pin8: hall[0], pin7: hall[1], pin5: hall[2]};
				end else begin
					func_pins = '{pin8: hall[2], pin7: hall[1], pin5: hall[0]};
				end
			end
			PULSE_DIRECTION_OUTPUT_TYPE: func_pins = '{pin8: step_q, pin7: dir_q,
				pin5: marker};
			default: func_pins = '{pin8: gray[1], pin7: gray[0], pin5: marker};
		endcase
	end

	pin_mux u_mux (
		.clk(clk),
		.rst(rst),
		.cfg_mode(mode_s2),
		.func_pins(func_pins),
		.sda_drive_low(sda_drive_low),
		.scl_drive_low(scl_drive_low),
		.pins_out(pins_out),
		.pin8_oe_n(pin8_oe_n),
		.pin7_oe_n(pin7_oe_n)
	);

	// Mode and option status flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_mode <= 1'b0;
			linear_enable <= 1'b0;
			full_turn_detect <= 1'b0;
		end else begin
			cfg_mode <= mode_s2;
			linear_enable <= (cfg.option == OPT_LINEAR);
			full_turn_detect <= (cfg.option == OPT_FULL_TURN);
		end
	end

	a_quad_one_bit: assert property (@(posedge clk) disable iff (rst)
		!$stable(gray) |-> $countones(gray ^ $past(gray)) == 1)
		else $error("quadrature changed two phases");
	a_quad_cw_order: assert property (@(posedge clk) disable iff (rst)
		step_ev && cw |=> gray == {~$past(gray[0]), $past(gray[1])})
		else $error("clockwise phase order wrong");
	a_quad_ccw_order: assert property (@(posedge clk) disable iff (rst)
		step_ev && !cw |=> gray == {$past(gray[0]), ~$past(gray[1])})
		else $error("counter-clockwise phase order wrong");
	a_marker_zero: assert property (@(posedge clk) disable iff (rst)
		pos == '0 |=> marker)
		else $error("marker missing at zero");
	a_marker_once: assert property (@(posedge clk) disable iff (rst)
		marker && $past(pos) != '0 |-> 1'b0)
		else $error("marker away from zero");
	a_step_width: assert property (@(posedge clk) disable iff (rst)
		step_q |-> $past(pos[0]))
		else $error("step pulse misplaced");
	a_dir_follow: assert property (@(posedge clk) disable iff (rst)
		step_ev |=> dir_q == $past(cw))
		else $error("direction not following");
	a_hall_valid: assert property (@(posedge clk) disable iff (rst)
		hall != 3'b000 && hall != 3'b111)
		else $error("illegal commutation code");
	a_cfg_release: assert property (@(posedge clk) disable iff (rst)
		mode_s2 && !sda_drive_low |=> pin8_oe_n)
		else $error("data pin not released");
endmodule : incremental_angle_output_encoder
`default_nettype wire

/* encoder_pkg.sv */
/*
 Shared constants and carriers for the incremental angle output encoder.
 Assumes a 12-bit absolute angle word arrives from the sensing front end.
*/
package encoder_pkg;
	localparam int ANGLE_BITS = 12;
	localparam int RES_MIN = 8;
	localparam int RES_MAX = 12;
	localparam logic [3:0] RES_RESET = 4'hC;
	localparam logic [11:0] ZERO_RESET = 12'h000;

	// Pulses per rotation selections for commutation
	typedef enum logic [1:0] {
		POLES_2,
		POLES_4,
		POLES_6,
		POLES_16
	} pole_sel_e;

	// Output type selection
	typedef enum logic [1:0] {
		QUADRATURE_OUTPUT_TYPE,
		COMMUTATION_OUTPUT_TYPE,
		PULSE_DIRECTION_OUTPUT_TYPE
	} out_type_e;

	// Option variants
	typedef enum logic [1:0] {
		OPT_DEFAULT,
		OPT_LINEAR,
		OPT_FULL_TURN
	} option_e;

	// Static configuration of the output stage
	typedef struct packed {
		out_type_e out_type;
		logic [3:0] res_bits;
		logic [11:0] zero_angle;
		pole_sel_e poles;
		option_e option;
	} enc_cfg_s;

	// Three output pins: pin8, pin7, pin5
	typedef struct packed {
		logic pin8;
		logic pin7;
		logic pin5;
	} pins_s;

	localparam logic [1:0] GRAY_RESET = 2'h0;
	localparam logic [2:0] HALL_RESET = 3'h1;
endpackage : encoder_pkg

/* angle_stepper.sv */
/*
 Steps a tracked angle one LSB at a time toward the measured angle.
 Assumes the measured angle is synchronous to clk and already scaled.
*/
`timescale 1ns/1ps
`default_nettype none
module angle_stepper #(
	parameter int WIDTH = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] target,
	input wire logic [3:0] res,
	output logic [WIDTH-1:0] pos,
	output logic step,
	output logic cw
);
	logic [WIDTH-1:0] diff;
	logic [WIDTH-1:0] mask;
	logic neg;

	// Difference wraps at the active resolution, so the shortest way is found
	assign mask = {WIDTH{1'b1}} >> (4'(WIDTH) - res);
	assign diff = (target - pos) & mask;
	assign neg = diff > (mask >> 1);

	// One LSB per clock toward the target
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos <= '0;
			step <= 1'b0;
			cw <= 1'b1;
		end else if (diff != '0) begin
			step <= 1'b1;
			cw <= ~neg;
			pos <= (neg ? pos - 1'b1 : pos + 1'b1) & mask;
		end else begin
			step <= 1'b0;
		end
	end
endmodule : angle_stepper
`default_nettype wire

/* pin_mux.sv */
/*
 Registered pin multiplexer with configuration-mode two-wire reuse.
 Assumes all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_mux
	import encoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_mode,
	input wire encoder_pkg::pins_s func_pins,
	input wire logic sda_drive_low,
	input wire logic scl_drive_low,
	output encoder_pkg::pins_s pins_out,
	output logic pin8_oe_n,
	output logic pin7_oe_n
);
	// Config mode releases pins 8/7 as open-drain data and clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_out <= '0;
			pin8_oe_n <= 1'b0;
			pin7_oe_n <= 1'b0;
		end else if (cfg_mode) begin
			pins_out <= {1'b0, 1'b0, 1'b0};
			pin8_oe_n <= ~sda_drive_low;
			pin7_oe_n <= ~scl_drive_low;
		end else begin
			pins_out <= func_pins;
			pin8_oe_n <= 1'b0;
			pin7_oe_n <= 1'b0;
		end
	end
endmodule : pin_mux
`default_nettype wire

/* motion_ctrl.sv */
/*
 Controller model that decodes the encoder pins into counts.
 Assumes the pins are registered on clk and the output type is static.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl
	import encoder_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire encoder_pkg::out_type_e kind,
	input wire encoder_pkg::pins_s pins,
	output var int cnt,
	output var int marks,
	output var int bad
);
	pins_s prev;
	logic moved;
	int d;
	int e;
	// Phase index, first phase rising first when turning clockwise
	function automatic int ph(input logic a, input logic b);
		return a ? (b ? 2 : 1) : (b ? 3 : 0);
	endfunction : ph
	// A step edge, or any edge of the phase pair
	assign moved = (kind == PULSE_DIRECTION_OUTPUT_TYPE) ? (pins.pin8 != prev.pin8)
		: (pins[2:1] != prev[2:1]);
	// Decode edges the way a real controller would; faults are counted
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prev <= '0;
			cnt <= 0;
			marks <= 0;
			bad <= 0;
		end else begin
			d = (ph(pins.pin8, pins.pin7) - ph(prev.pin8, prev.pin7)) & 3;
			e = int'(moved && pins.pin5 && prev.pin5);
			if (kind == COMMUTATION_OUTPUT_TYPE) begin
				e = int'(pins != prev && (!$onehot(pins ^ prev) || &pins || pins == 3'h0));
				cnt <= cnt + int'(pins != prev);
			end else if (kind == PULSE_DIRECTION_OUTPUT_TYPE) begin
				cnt <= cnt + (moved ? (pins.pin7 ? 1 : -1) : 0);
			end else begin
				cnt <= cnt + (d == 1 ? 1 : (d == 3 ? -1 : 0));
				e = e + int'(d == 2);
			end
			if (kind != COMMUTATION_OUTPUT_TYPE && pins.pin5 && !prev.pin5) begin
				marks <= marks + 1;
			end
			bad <= bad + e;
			prev <= pins;
		end
	end
endmodule : motion_ctrl
`default_nettype wire

/* incremental_angle_output_encoder_test.sv */
/*
 Bench: random and clockwise angle walks, integer model against the controller model.
 Assumes encoder_pkg and motion_ctrl are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module incremental_angle_output_encoder_test;
	import encoder_pkg::*;
	logic clk, rst, mode_pin, sda_drive_low, scl_drive_low;
	logic [11:0] angle_in;
	enc_cfg_s cfg;
	pins_s pins_out;
	logic pin8_oe_n, pin7_oe_n, cfg_mode, linear_enable, full_turn_detect;
	int cnt, marks, bad, mismatches, samples_checked, seed, cycles;
	int ang, sc, e_cnt, e_mk, b_cnt, b_mk, b_bad;
	incremental_angle_output_encoder i_dut (.clk(clk), .rst(rst), .mode_pin(mode_pin),
		.angle_in(angle_in), .cfg(cfg), .sda_drive_low(sda_drive_low),
		.scl_drive_low(scl_drive_low), .pins_out(pins_out), .pin8_oe_n(pin8_oe_n),
		.pin7_oe_n(pin7_oe_n), .cfg_mode(cfg_mode), .linear_enable(linear_enable),
		.full_turn_detect(full_turn_detect));
	motion_ctrl i_ctrl (.clk(clk), .rst(rst), .kind(cfg.out_type), .pins(pins_out),
		.cnt(cnt), .marks(marks), .bad(bad));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Cycle ceiling against hangs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 70000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic end_sim;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Scaled position relative to the programmed zero
	function automatic int scale(input int a);
		return ((a - int'(cfg.zero_angle)) & 4095) >> (12 - int'(cfg.res_bits));
	endfunction : scale
	// New setting, reset, settle, then take the baselines
	task automatic setup(input out_type_e t, input int r, input int p);
		@(posedge clk);
		cfg.out_type <= t;
		cfg.res_bits <= 4'(r);
		cfg.poles <= pole_sel_e'(p);
		cfg.zero_angle <= 12'($random(seed) % 342);
		angle_in <= 12'h000;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (400) @(posedge clk);
		@(negedge clk);
		ang = 0;
		sc = scale(0);
		e_cnt = 0;
		e_mk = 0;
		b_cnt = cnt;
		b_mk = marks;
		b_bad = bad;
	endtask : setup
	// One angle count every four cycles, random or clockwise
	task automatic walk(input int n, input bit sweep);
		int s;
		repeat (n) begin
			@(posedge clk);
			ang = (ang + ((sweep || $random(seed) % 2 == 0) ? 1 : -1)) & 4095;
			angle_in <= 12'(ang);
			s = scale(ang);
			e_cnt += (s == sc) ? 0 : ((s == sc + 1 || s + 1 < sc) ? 1 : -1);
			e_mk += int'(s == 0 && sc != 0);
			sc = s;
			repeat (3) @(posedge clk);
		end
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk(bad - b_bad, 0);
	endtask : walk
	task automatic counts;
		chk(cnt - b_cnt, e_cnt);
		chk(marks - b_mk, e_mk);
	endtask : counts
	// Main sequence
	initial begin
		seed = 71860;
		rst = 1'b1;
		mode_pin = 1'b0;
		sda_drive_low = 1'b0;
		scl_drive_low = 1'b0;
		angle_in = 12'h000;
		cfg = '0;
		cfg.res_bits = 4'hC;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int o = 0; o < 3; o++) begin
			@(posedge clk);
			cfg.option <= option_e'(o);
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk({linear_enable, full_turn_detect}, {o == 1, o == 2});
		end
		@(posedge clk);
		mode_pin <= 1'b1;
		sda_drive_low <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({cfg_mode, pins_out, pin8_oe_n, pin7_oe_n}, 6'h21);
		sda_drive_low <= 1'b0;
		scl_drive_low <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk({cfg_mode, pins_out, pin8_oe_n, pin7_oe_n}, 6'h22);
		scl_drive_low <= 1'b0;
		mode_pin <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({cfg_mode, pin8_oe_n, pin7_oe_n}, 3'h0);
		for (int r = 8; r <= 12; r++) begin
			setup(QUADRATURE_OUTPUT_TYPE, r, 0);
			walk(700, 1'b0);
			counts();
		end
		setup(QUADRATURE_OUTPUT_TYPE, 12, 0);
		walk(4200, 1'b1);
		counts();
		setup(PULSE_DIRECTION_OUTPUT_TYPE, 10, 0);
		walk(700, 1'b0);
		counts();
		for (int p = 0; p < 4; p++) begin
			setup(COMMUTATION_OUTPUT_TYPE, 12, p);
			walk(700, 1'b1);
			chk(cnt > b_cnt, 1'b1);
		end
		end_sim();
	end
endmodule : incremental_angle_output_encoder_test
`default_nettype wire
